// *** hw/bmamd_decoder.sv ***
`timescale 1ns/1ns
module bmamd_decoder #(
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter logic [31:0] PFLASH_BYTES = 32'h0008_0000,
  parameter logic [31:0] SRAM_BYTES = 32'h0000_8000,
  parameter logic [63:0] OPT_SLOTS = 64'hffff_ffff_ffff_ffff
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] bootMode,
  input wire logic errEnable,
  input wire logic mapWrEn,
  input wire logic [31:0] mapWrData,
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic [1:0] reqSize,
  input wire logic reqWrite,
  input wire logic rdInValid,
  input wire logic [31:0] rdIn,
  input wire logic dbgReq,
  input wire logic dbgRecovery,
  output logic [31:0] addressMapConfig,
  output logic mapWrRefused,
  output logic securedMode,
  output logic selValid,
  output bmamd_pkg::bmamd_target_type selTarget,
  output logic [31:0] selOffset,
  output logic [5:0] selSlot,
  output logic selWrite,
  output logic [1:0] selSize,
  output logic respError,
  output logic rdOutValid,
  output logic [31:0] rdOut,
  output logic dbgGrant,
  output logic dbgDeny
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic bootDone_r, dfAtZero_r, mapWrRefused_r, selValid_r, selWrite_r, respError_r;
  logic rdOutValid_r, dbgGrant_r, dbgDeny_r, securedMode_r;
  bmamd_pkg::bmamd_mode_type mode_r;
  bmamd_pkg::bmamd_target_type selTarget_r;
  logic [7:0] mapLow_r;
  logic [5:0] selSlot_r;
  logic [1:0] selSize_r, selOff_r;
  logic [31:0] selOffset_r, rdOut_r;

  // ----------------------------------------
  // Mode classification
  // ----------------------------------------
  logic secExp, secured, dfBoot, extUsable;
  assign secExp = (mode_r == bmamd_pkg::MODE_SEC_EXP);
  assign dfBoot = (mode_r == bmamd_pkg::MODE_NORM_DFBOOT) ||
                  (mode_r == bmamd_pkg::MODE_SEC_DFBOOT);
  assign secured = secExp || (mode_r == bmamd_pkg::MODE_SEC_SINGLE) ||
                   (mode_r == bmamd_pkg::MODE_SEC_DFBOOT);
  // External bus only exists on some variants and is shut off in secured
  // single-chip and both data flash boot modes
  assign extUsable = HAS_EXT_BUS && !dfBoot &&
                     (mode_r != bmamd_pkg::MODE_SEC_SINGLE);

  // ----------------------------------------
  // Map code checking
  // ----------------------------------------
  // Legal base nibbles per mode; secured expanded excludes flash, the
  // secured single-chip and data flash boot modes exclude external bus
  function automatic logic nib_ok(input bmamd_pkg::bmamd_mode_type m, input logic [3:0] n);
    logic base;
    base = (n == bmamd_pkg::NIB_NONE) || (n == bmamd_pkg::NIB_SRAM);
    unique case (m)
      bmamd_pkg::MODE_NORM_SINGLE, bmamd_pkg::MODE_NORM_EXP: begin
        nib_ok = base || (n == bmamd_pkg::NIB_PFLASH) || (n == bmamd_pkg::NIB_EXT);
      end
      bmamd_pkg::MODE_SEC_EXP: begin
        nib_ok = base || (n == bmamd_pkg::NIB_EXT);
      end
      bmamd_pkg::MODE_SEC_SINGLE, bmamd_pkg::MODE_NORM_DFBOOT,
      bmamd_pkg::MODE_SEC_DFBOOT: begin
        nib_ok = base || (n == bmamd_pkg::NIB_PFLASH);
      end
      default: begin
        nib_ok = 1'b0;
      end
    endcase
  endfunction

  logic codeOk, mapWrTake, mapWrDrop;
  // Program flash at both bases is never a legal code
  assign codeOk = (mapWrData[31:8] == bmamd_pkg::MAP_PREFIX) &&
                  nib_ok(mode_r, mapWrData[7:4]) && nib_ok(mode_r, mapWrData[3:0]) &&
                  !((mapWrData[7:4] == bmamd_pkg::NIB_PFLASH) &&
                    (mapWrData[3:0] == bmamd_pkg::NIB_PFLASH));
  assign mapWrTake = bootDone_r && mapWrEn && codeOk;
  assign mapWrDrop = bootDone_r && mapWrEn && !codeOk;

  // Reset code by mode, loaded at the first edge after reset release
  bmamd_pkg::bmamd_mode_type strapMode;
  logic [7:0] rstCode;
  assign strapMode = bmamd_pkg::bmamd_mode_type'(bootMode);
  assign rstCode = (strapMode == bmamd_pkg::MODE_NORM_SINGLE) ? bmamd_pkg::MAP_RST_NORM_SINGLE :
                   (strapMode == bmamd_pkg::MODE_SEC_SINGLE) ? bmamd_pkg::MAP_RST_SEC_SINGLE :
                   (strapMode == bmamd_pkg::MODE_NORM_EXP) ? bmamd_pkg::MAP_RST_NORM_EXP :
                   (strapMode == bmamd_pkg::MODE_SEC_EXP) ? bmamd_pkg::MAP_RST_SEC_EXP :
                   bmamd_pkg::MAP_RST_DFBOOT;
  logic strapDf;
  assign strapDf = (strapMode == bmamd_pkg::MODE_NORM_DFBOOT) ||
                   (strapMode == bmamd_pkg::MODE_SEC_DFBOOT);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [2:0] region;
  logic [3:0] baseNib;
  logic misaligned, inSramWin;
  logic [31:0] regOff, sramOff, pfOff, dfOff, decOffset;
  assign region = reqAddr[31:29];
  assign regOff = {3'h0, reqAddr[28:0]};
  assign baseNib = (region == bmamd_pkg::REGION_BASE0) ? mapLow_r[3:0] : mapLow_r[7:4];
  // Natural alignment only; an access that breaks it decodes to no target
  assign misaligned = (reqSize == bmamd_pkg::SIZE_HALF) ? reqAddr[0] :
                      (reqSize == bmamd_pkg::SIZE_WORD) ? (reqAddr[1:0] != 2'h0) :
                      (reqSize != bmamd_pkg::SIZE_BYTE);
  assign inSramWin = (regOff < bmamd_pkg::SRAM_WIN_BYTES);
  // Bits above the SRAM size are dropped; SRAM_BYTES must be a power of two
  assign sramOff = regOff & (SRAM_BYTES - 32'h1);

  // Target for the two configurable bases
  bmamd_pkg::bmamd_target_type nibTarget, periphTarget, decTarget;
  assign nibTarget =
    (baseNib == bmamd_pkg::NIB_SRAM) ?
      (inSramWin ? bmamd_pkg::TGT_SRAM : bmamd_pkg::TGT_NONE) :
    (baseNib == bmamd_pkg::NIB_EXT) ?
      (extUsable ? bmamd_pkg::TGT_EXT : bmamd_pkg::TGT_NONE) :
    (baseNib == bmamd_pkg::NIB_PFLASH) ?
      ((!secExp && regOff < PFLASH_BYTES) ? bmamd_pkg::TGT_PFLASH : bmamd_pkg::TGT_NONE) :
    ((region == bmamd_pkg::REGION_BASE0) && dfAtZero_r && (regOff < bmamd_pkg::DFLASH_BYTES)) ?
      bmamd_pkg::TGT_DFLASH : bmamd_pkg::TGT_NONE;

  // Peripheral space: fixed slots, flash programming window, data flash
  logic inPeriph, inSlots, inPfWin, inDfWin;
  logic [5:0] slotIdx;
  logic [63:0] slotMask;
  assign inPeriph = (reqAddr[31:26] == bmamd_pkg::PERIPH_TOP);
  assign inSlots = inPeriph && (reqAddr[25:20] == bmamd_pkg::SLOT_AREA);
  assign slotIdx = reqAddr[19:14];
  // Optional modules that a variant leaves out fall back to reserved
  assign slotMask = bmamd_pkg::SLOT_FIXED_MASK | (bmamd_pkg::SLOT_OPT_MASK & OPT_SLOTS);
  assign pfOff = reqAddr - bmamd_pkg::PFLASH_WIN_BASE;
  assign dfOff = reqAddr - bmamd_pkg::DFLASH_BASE;
  assign inPfWin = (reqAddr >= bmamd_pkg::PFLASH_WIN_BASE) && (pfOff < PFLASH_BYTES);
  assign inDfWin = (reqAddr >= bmamd_pkg::DFLASH_BASE) && (dfOff < bmamd_pkg::DFLASH_BYTES);

  assign periphTarget =
    (inSlots && slotMask[slotIdx]) ? bmamd_pkg::TGT_PERIPH :
    (inPfWin && !secExp) ? bmamd_pkg::TGT_PFLASH :
    (inDfWin && !secExp) ? bmamd_pkg::TGT_DFLASH :
    bmamd_pkg::TGT_NONE;

  // Final selection; misaligned accesses never reach a target
  assign decTarget =
    misaligned ? bmamd_pkg::TGT_NONE :
    ((region == bmamd_pkg::REGION_BASE0) || (region == bmamd_pkg::REGION_BASE1)) ? nibTarget :
    (region == bmamd_pkg::REGION_SRAM) ?
      (inSramWin ? bmamd_pkg::TGT_SRAM : bmamd_pkg::TGT_NONE) :
    inPeriph ? periphTarget : bmamd_pkg::TGT_NONE;
  assign decOffset =
    (decTarget == bmamd_pkg::TGT_SRAM) ? sramOff :
    (decTarget == bmamd_pkg::TGT_PERIPH) ? {18'h0, reqAddr[13:0]} :
    ((decTarget == bmamd_pkg::TGT_PFLASH) && inPeriph) ? pfOff :
    ((decTarget == bmamd_pkg::TGT_DFLASH) && inPeriph) ? dfOff :
    regOff;

  // ----------------------------------------
  // Read lane steering
  // ----------------------------------------
  logic [31:0] steered;
  bmamd_lane_steer u_lane (
    .wordIn(rdIn),
    .accSize(selSize_r),
    .byteOff(selOff_r),
    .steered(steered)
  );

  // ----------------------------------------
  // Boot strap capture and map configuration
  // ----------------------------------------
  // Reset loads a constant; the mode-dependent code follows one edge later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bootDone_r <= 1'b0;
      mode_r <= bmamd_pkg::MODE_NORM_SINGLE;
      mapLow_r <= bmamd_pkg::MAP_EMPTY;
      dfAtZero_r <= 1'b0;
      mapWrRefused_r <= 1'b0;
    end else begin
      mapWrRefused_r <= mapWrDrop;
      if (!bootDone_r) begin
        bootDone_r <= 1'b1;
        mode_r <= strapMode;
        mapLow_r <= rstCode;
        dfAtZero_r <= strapDf;
      end else if (mapWrTake) begin
        mapLow_r <= mapWrData[7:0];
        dfAtZero_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registered decode result
  // ----------------------------------------
  // Errors only surface when reporting is enabled; otherwise the access
  // quietly selects nothing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      selValid_r <= 1'b0;
      selTarget_r <= bmamd_pkg::TGT_NONE;
      selOffset_r <= 32'h0;
      selSlot_r <= 6'h0;
      selWrite_r <= 1'b0;
      selSize_r <= bmamd_pkg::SIZE_BYTE;
      selOff_r <= 2'h0;
      respError_r <= 1'b0;
    end else begin
      selValid_r <= reqValid && bootDone_r;
      respError_r <= reqValid && bootDone_r && errEnable &&
                     (decTarget == bmamd_pkg::TGT_NONE);
      if (reqValid && bootDone_r) begin
        selTarget_r <= decTarget;
        selOffset_r <= decOffset;
        selSlot_r <= slotIdx;
        selWrite_r <= reqWrite;
        selSize_r <= reqSize;
        selOff_r <= reqAddr[1:0];
      end
    end
  end

  // ----------------------------------------
  // Read data and debug gate
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdOutValid_r <= 1'b0;
      rdOut_r <= 32'h0;
      dbgGrant_r <= 1'b0;
      dbgDeny_r <= 1'b0;
      securedMode_r <= 1'b0;
    end else begin
      rdOutValid_r <= rdInValid;
      if (rdInValid) begin
        rdOut_r <= steered;
      end
      dbgGrant_r <= dbgReq && bootDone_r && (!secured || dbgRecovery);
      dbgDeny_r <= dbgReq && !(bootDone_r && (!secured || dbgRecovery));
      securedMode_r <= bootDone_r && secured;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign addressMapConfig = {bmamd_pkg::MAP_PREFIX, mapLow_r};
  assign mapWrRefused = mapWrRefused_r;
  assign securedMode = securedMode_r;
  assign selValid = selValid_r;
  assign selTarget = selTarget_r;
  assign selOffset = selOffset_r;
  assign selSlot = selSlot_r;
  assign selWrite = selWrite_r;
  assign selSize = selSize_r;
  assign respError = respError_r;
  assign rdOutValid = rdOutValid_r;
  assign rdOut = rdOut_r;
  assign dbgGrant = dbgGrant_r;
  assign dbgDeny = dbgDeny_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_refused_map_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    mapWrDrop |=> (mapLow_r == $past(mapLow_r)) && mapWrRefused_r)
    else $error("refused map code changed the map");

  a_secexp_reset_code: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(bootDone_r) && secExp |-> addressMapConfig[7:0] == bmamd_pkg::MAP_RST_SEC_EXP)
    else $error("secured expanded boot code wrong");

  a_secexp_no_flash: assert property (
    @(posedge mclk) disable iff (!rst_b)
    selValid_r && secExp |-> (selTarget_r != bmamd_pkg::TGT_PFLASH) &&
                             (selTarget_r != bmamd_pkg::TGT_DFLASH))
    else $error("flash selected in secured expanded mode");

  a_dfboot_zero_flash: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reqValid && bootDone_r && dfAtZero_r && (reqAddr < bmamd_pkg::DFLASH_BYTES) &&
    !misaligned |=> selTarget_r == bmamd_pkg::TGT_DFLASH)
    else $error("data flash not at zero after boot");

  a_periph_slot_fixed: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reqValid && bootDone_r && (reqAddr == 32'hfc00_4000) && (reqSize == bmamd_pkg::SIZE_WORD)
    |=> (selTarget_r == bmamd_pkg::TGT_PERIPH) && (selSlot_r == 6'h01))
    else $error("crossbar slot not decoded");

  a_sram_mirror_offset: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reqValid && bootDone_r && (region == bmamd_pkg::REGION_SRAM) && inSramWin &&
    !misaligned
    |=> (selTarget_r == bmamd_pkg::TGT_SRAM) && (selOffset_r < SRAM_BYTES))
    else $error("SRAM mirror offset out of range");

  a_error_gated: assert property (
    @(posedge mclk) disable iff (!rst_b)
    respError_r |-> $past(errEnable) && (selTarget_r == bmamd_pkg::TGT_NONE) && selValid_r)
    else $error("bus error without enable or with target");

  a_secure_debug_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    dbgGrant_r && securedMode |-> $past(dbgRecovery))
    else $error("secured debug granted without recovery");

  a_misaligned_none: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reqValid && bootDone_r && misaligned |=> selTarget_r == bmamd_pkg::TGT_NONE)
    else $error("misaligned access reached a target");

  a_byte_lane_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rdInValid && (selSize_r == bmamd_pkg::SIZE_BYTE) && (selOff_r == 2'h0)
    |=> rdOut_r == {24'h0, $past(rdIn[31:24])})
    else $error("byte lane zero not top byte");

endmodule

// *** hw/bmamd_lane_steer.sv ***
`timescale 1ns/1ns
module bmamd_lane_steer (
  input wire logic [31:0] wordIn,
  input wire logic [1:0] accSize,
  input wire logic [1:0] byteOff,
  output logic [31:0] steered
);

  // ----------------------------------------
  // Big-endian lane selection
  // ----------------------------------------
  // Byte 0 lives in the top lane, so a byte read shifts by three minus offset
  logic [4:0] byteShift;
  logic [31:0] byteWord;
  logic [15:0] halfSel;
  assign byteShift = {~byteOff, 3'h0};
  assign byteWord = wordIn >> byteShift;
  assign halfSel = byteOff[1] ? wordIn[15:0] : wordIn[31:16];

  // Narrow results sit in the low bits; a word passes whole, so a narrow
  // register comes back in the top lanes followed by its neighbours
  assign steered = (accSize == bmamd_pkg::SIZE_BYTE) ? {24'h0, byteWord[7:0]} :
                   (accSize == bmamd_pkg::SIZE_HALF) ? {16'h0, halfSel} :
                   wordIn;

endmodule

// *** hw/bmamd_pkg.sv ***
package bmamd_pkg;

  // ----------------------------------------
  // Operating modes and decode targets
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_NORM_SINGLE,
    MODE_SEC_SINGLE,
    MODE_NORM_EXP,
    MODE_SEC_EXP,
    MODE_NORM_DFBOOT,
    MODE_SEC_DFBOOT
  } bmamd_mode_type;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_EXT,
    TGT_SRAM,
    TGT_PFLASH,
    TGT_DFLASH,
    TGT_PERIPH
  } bmamd_target_type;

  // ----------------------------------------
  // Access sizes
  // ----------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ----------------------------------------
  // Address map configuration codes
  // ----------------------------------------
  localparam logic [23:0] MAP_PREFIX = 24'hf0000b;
  localparam logic [7:0] MAP_RST_NORM_SINGLE = 8'h98;
  localparam logic [7:0] MAP_RST_SEC_SINGLE = 8'h08;
  localparam logic [7:0] MAP_RST_NORM_EXP = 8'h89;
  localparam logic [7:0] MAP_RST_SEC_EXP = 8'h09;
  localparam logic [7:0] MAP_RST_DFBOOT = 8'h80;
  localparam logic [7:0] MAP_EMPTY = 8'h00;
  localparam logic [3:0] NIB_NONE = 4'h0;
  localparam logic [3:0] NIB_PFLASH = 4'h8;
  localparam logic [3:0] NIB_EXT = 4'h9;
  localparam logic [3:0] NIB_SRAM = 4'hb;

  // ----------------------------------------
  // Region layout
  // ----------------------------------------
  localparam logic [2:0] REGION_BASE0 = 3'h0;
  localparam logic [2:0] REGION_BASE1 = 3'h1;
  localparam logic [2:0] REGION_SRAM = 3'h2;
  localparam logic [5:0] PERIPH_TOP = 6'h3f;
  localparam logic [5:0] SLOT_AREA = 6'h00;
  localparam logic [31:0] SRAM_WIN_BYTES = 32'h0008_0000;
  localparam logic [31:0] PFLASH_WIN_BASE = 32'hfc10_0000;
  localparam logic [31:0] DFLASH_BASE = 32'hfe00_0000;
  localparam logic [31:0] DFLASH_BYTES = 32'h0000_8000;
  localparam logic [63:0] SLOT_FIXED_MASK = 64'h1586_287f_0007_0007;
  localparam logic [63:0] SLOT_OPT_MASK = 64'h0218_4180_0000_0000;

endpackage

// *** tb/bmamd_target_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Read data source standing behind the decoder
// ----------------------------------------
module bmamd_target_model #(
  parameter logic [31:0] DATA_WORD = 32'ha1b2c3d4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic selValid,
  input wire logic respError,
  input wire logic selWrite,
  output logic rdInValid,
  output logic [31:0] rdIn
);
  // Answers each good read decode one cycle later; idle data toggles so stale lanes never match
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdInValid <= 1'b0;
      rdIn <= 32'h0;
    end else begin
      rdInValid <= selValid && !respError && !selWrite;
      rdIn <= (selValid && !respError && !selWrite) ? DATA_WORD : ~rdIn;
    end
  end
endmodule

// *** tb/boot_mode_address_map_decoder_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: value mismatch", $time); end end
module boot_mode_address_map_decoder_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam logic [31:0] WORD_VAL = 32'ha1b2c3d4;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] bootMode = 3'h0;
  logic errEnable = 1'b0;
  logic mapWrEn = 1'b0;
  logic [31:0] mapWrData = 32'h0;
  logic reqValid = 1'b0;
  logic [31:0] reqAddr = 32'h0;
  logic [1:0] reqSize = 2'h0;
  logic reqWrite = 1'b0;
  logic dbgReq = 1'b0;
  logic dbgRecovery = 1'b0;
  logic rdInValid, mapWrRefused, securedMode, selValid, selWrite, respError;
  logic rdOutValid, dbgGrant, dbgDeny;
  logic [31:0] rdIn, addressMapConfig, selOffset, rdOut;
  logic [5:0] selSlot;
  logic [1:0] selSize;
  bmamd_pkg::bmamd_target_type selTarget;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] secExpCodes [9] = '{8'h09, 8'h00, 8'h0b, 8'h90, 8'h99, 8'h9b, 8'hb0, 8'hb9, 8'hbb};
  logic [7:0] dfCodes [8] = '{8'h00, 8'h08, 8'h0b, 8'h8b, 8'hb0, 8'hb8, 8'hbb, 8'h80};

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  // Slot 39 dropped to model a variant lacking that module
  bmamd_decoder #(.OPT_SLOTS(64'hffff_ff7f_ffff_ffff)) dut (
    .mclk(mclk), .rst_b(rst_b), .bootMode(bootMode), .errEnable(errEnable),
    .mapWrEn(mapWrEn), .mapWrData(mapWrData), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqSize(reqSize), .reqWrite(reqWrite), .rdInValid(rdInValid), .rdIn(rdIn),
    .dbgReq(dbgReq), .dbgRecovery(dbgRecovery), .addressMapConfig(addressMapConfig),
    .mapWrRefused(mapWrRefused), .securedMode(securedMode), .selValid(selValid),
    .selTarget(selTarget), .selOffset(selOffset), .selSlot(selSlot), .selWrite(selWrite),
    .selSize(selSize), .respError(respError), .rdOutValid(rdOutValid), .rdOut(rdOut),
    .dbgGrant(dbgGrant), .dbgDeny(dbgDeny)
  );

  bmamd_target_model #(.DATA_WORD(WORD_VAL)) target (
    .mclk(mclk), .rst_b(rst_b), .selValid(selValid), .respError(respError),
    .selWrite(selWrite), .rdInValid(rdInValid), .rdIn(rdIn)
  );

  // ----------------------------------------
  // Shared bus tasks
  // ----------------------------------------
  task automatic final_report;
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Mode strap is set while reset is held; requests start two edges after release
  task automatic boot(input logic [2:0] mode, input logic err);
    @(posedge mclk);
    rst_b <= 1'b0;
    bootMode <= mode;
    errEnable <= err;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic access(input logic [31:0] a, input logic [1:0] sz,
                        input bmamd_pkg::bmamd_target_type tgt, input logic err);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqSize <= sz;
    @(posedge mclk);
    reqValid <= 1'b0;
    #1;
    `CHK(selValid, 1'b1)
    `CHK(selTarget, tgt)
    `CHK(selSize, sz)
    `CHK(respError, err)
  endtask

  task automatic mapWrite(input logic [7:0] code, input logic [7:0] expCode, input logic refused);
    @(posedge mclk);
    mapWrEn <= 1'b1;
    mapWrData <= {24'hf0000b, code};
    @(posedge mclk);
    mapWrEn <= 1'b0;
    #1;
    `CHK(addressMapConfig, {24'hf0000b, expCode})
    `CHK(mapWrRefused, refused)
  endtask

  task automatic debug(input logic recov, input logic grant);
    @(posedge mclk);
    dbgReq <= 1'b1;
    dbgRecovery <= recov;
    @(posedge mclk);
    dbgReq <= 1'b0;
    #1;
    `CHK(dbgGrant, grant)
    `CHK(dbgDeny, !grant)
  endtask

  // Bounded wait for steered read data; polls up to six edges and judges the
  // first rdOutValid pulse it sees, including one already there at the first edge
  task automatic readBack(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (rdOutValid !== 1'b1 && n < 6);
    if (rdOutValid !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: read data never came", $time);
      final_report();
    end
    `CHK(rdOut, exp)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic secExpanded;
    boot(3'h3, 1'b1);
    `CHK(addressMapConfig, 32'hf0000b09)
    `CHK(securedMode, 1'b1)
    access(32'h0000_0100, 2'h2, bmamd_pkg::TGT_EXT, 1'b0);
    access(32'h2000_0000, 2'h2, bmamd_pkg::TGT_NONE, 1'b1);
    access(32'hfe00_0000, 2'h2, bmamd_pkg::TGT_NONE, 1'b1);
    access(32'hfc10_0000, 2'h2, bmamd_pkg::TGT_NONE, 1'b1);
    access(32'h4000_8004, 2'h2, bmamd_pkg::TGT_SRAM, 1'b0);
    `CHK(selOffset, 32'h4)
    for (int i = 0; i < 9; i++) mapWrite(secExpCodes[i], secExpCodes[i], 1'b0);
    access(32'h2000_0000, 2'h2, bmamd_pkg::TGT_SRAM, 1'b0);
    mapWrite(8'h99, 8'h99, 1'b0);
    access(32'h2000_0000, 2'h2, bmamd_pkg::TGT_EXT, 1'b0);
    mapWrite(8'h08, 8'h99, 1'b1);
    mapWrite(8'h80, 8'h99, 1'b1);
    debug(1'b0, 1'b0);
    debug(1'b1, 1'b1);
  endtask

  task automatic dataFlashBoot;
    boot(3'h4, 1'b0);
    `CHK(addressMapConfig, 32'hf0000b80)
    access(32'h0000_0010, 2'h2, bmamd_pkg::TGT_DFLASH, 1'b0);
    `CHK(selOffset, 32'h10)
    access(32'hfe00_0010, 2'h2, bmamd_pkg::TGT_DFLASH, 1'b0);
    access(32'h0000_8000, 2'h2, bmamd_pkg::TGT_NONE, 1'b0);
    mapWrite(8'h99, 8'h80, 1'b1);
    for (int i = 0; i < 8; i++) mapWrite(dfCodes[i], dfCodes[i], 1'b0);
    access(32'h2000_0000, 2'h2, bmamd_pkg::TGT_PFLASH, 1'b0);
    access(32'hfc10_0010, 2'h2, bmamd_pkg::TGT_PFLASH, 1'b0);
    `CHK(selOffset, 32'h10)
    debug(1'b0, 1'b1);
    access(32'hfc00_4000, 2'h2, bmamd_pkg::TGT_PERIPH, 1'b0);
    `CHK(selSlot, 6'h01)
    access(32'hfc00_c000, 2'h2, bmamd_pkg::TGT_NONE, 1'b0);
    access(32'hfc09_c000, 2'h2, bmamd_pkg::TGT_NONE, 1'b0);
    access(32'hfc0a_0000, 2'h2, bmamd_pkg::TGT_PERIPH, 1'b0);
    access(32'hfc04_4001, 2'h0, bmamd_pkg::TGT_PERIPH, 1'b0);
    readBack({24'h0, WORD_VAL[23:16]});
    access(32'hfc04_4003, 2'h0, bmamd_pkg::TGT_PERIPH, 1'b0);
    readBack({24'h0, WORD_VAL[7:0]});
    access(32'hfc04_4002, 2'h1, bmamd_pkg::TGT_PERIPH, 1'b0);
    readBack({16'h0, WORD_VAL[15:0]});
    access(32'hfc04_4000, 2'h0, bmamd_pkg::TGT_PERIPH, 1'b0);
    readBack({24'h0, WORD_VAL[31:24]});
    access(32'hfc04_4000, 2'h2, bmamd_pkg::TGT_PERIPH, 1'b0);
    readBack(WORD_VAL);
    access(32'hfc04_4001, 2'h1, bmamd_pkg::TGT_NONE, 1'b0);
  endtask

  task automatic securedFlashBoot;
    boot(3'h5, 1'b1);
    `CHK(securedMode, 1'b1)
    access(32'h0000_0000, 2'h2, bmamd_pkg::TGT_DFLASH, 1'b0);
    access(32'hfc00_4002, 2'h1, bmamd_pkg::TGT_PERIPH, 1'b0);
    access(32'hfc00_4002, 2'h2, bmamd_pkg::TGT_NONE, 1'b1);
    debug(1'b0, 1'b0);
    debug(1'b1, 1'b1);
  endtask

  initial begin
    secExpanded();
    dataFlashBoot();
    securedFlashBoot();
    final_report();
  end
endmodule
